// [bench/pin_world.sv]
// pin_world: the board around one bank of io lines, with pull-ups and external drivers
// assumes: oe_n low means the chip drives the line; ext_en marks lines the board drives
module pin_world (
  // chip side
  input wire logic [31:0] out,
  input wire logic [31:0] oe_n,
  input wire logic [31:0] pull,
  // board side
  input wire logic [31:0] ext_val,
  input wire logic [31:0] ext_en,
  output logic [31:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  // the chip wins, then the board; an idle line rests on its pull-up, or low without it
  // the board alone sets line 3 of bank b while the chip is in reset, as the boot level
  assign level = (~oe_n & out) | (oe_n & ext_en & ext_val) | (oe_n & ~ext_en & pull);
endmodule // pin_world

// [bench/tb_top.sv]
// tb_top: self-checking bench for io_glue_top against an integer model of ownership and pull-ups
// assumes: pin_world closes each bank's lines; outputs follow the hand-over timing
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic cfg_write = 1'b0;
  logic cfg_bank = 1'b0;
  io_glue_pkg::line_cfg_s cfg = '0;
  io_glue_pkg::line_drive_s bg = '0, bfa = '0, bfb = '0, cg = '0, cfa = '0, cfb = '0;
  logic [31:0] st_b, st_c, b_gi, b_fai, b_fbi, c_gi, c_fai, c_fbi, pb_o, pb_oen, pb_pu, pc_o, pc_oen, pc_pu;
  logic [31:0] irq, clk_en, lvl_b, lvl_c;
  logic [31:0] clk_req = '0, ext_bv = '0, ext_cv = '0, ext_ce = '0;
  logic [31:0] ext_be = 32'h8; // board holds b3 low through reset to pick the boot level
  logic [6:0] sys_irq = '0;
  logic [2:0] csa = '0;
  logic [7:0] smc_cs = 8'hff;
  logic [7:0] ebi_cs;
  logic [25:0] addr = '0;
  logic [15:0] dhi_o = '0;
  logic [15:0] dhi_i;
  logic [24:0] ebi_addr;
  logic d32 = 1'b0, n16 = 1'b0, sd_cs = 1'b1, rd_n = 1'b1, wr_n = 1'b1, dhi_oe = 1'b0, boot, nhi;
  logic [31:0] m_st [2];
  logic [31:0] m_pu [2];
  int failures = 0;
  int n_tests = 0;
  int seed = 95;

  io_glue_top uut (.clock(clock), .nrst(nrst), .cfg_write(cfg_write), .cfg_bank(cfg_bank), .cfg(cfg),
    .line_peripheral_status_b(st_b), .line_peripheral_status_c(st_c), .bankb_gpio(bg), .bankb_fa(bfa),
    .bankb_fb(bfb), .bankb_gpio_in(b_gi), .bankb_fa_in(b_fai), .bankb_fb_in(b_fbi), .bankc_gpio(cg),
    .bankc_fa(cfa), .bankc_fb(cfb), .bankc_gpio_in(c_gi), .bankc_fa_in(c_fai), .bankc_fb_in(c_fbi),
    .pinb_in(lvl_b), .pinb_out(pb_o), .pinb_oe_n(pb_oen), .pinb_pullup(pb_pu), .pinc_in(lvl_c),
    .pinc_out(pc_o), .pinc_oe_n(pc_oen), .pinc_pullup(pc_pu), .boot_mode_select_pin(boot),
    .sys_irq_src(sys_irq), .irq_sources(irq), .clk_en_req(clk_req), .periph_clk_en(clk_en),
    .chip_select_assign_setting(csa), .data_bus_32(d32), .nand_16bit(n16), .smc_cs_n(smc_cs),
    .sdram_cs_n(sd_cs), .smc_rd_n(rd_n), .smc_wr_n(wr_n), .addr(addr), .dhi_out(dhi_o), .dhi_oe(dhi_oe),
    .dhi_in(dhi_i), .ebi_addr(ebi_addr), .ebi_cs_n(ebi_cs), .nand_hi_lane_en(nhi));
  pin_world world_b (.out(pb_o), .oe_n(pb_oen), .pull(pb_pu), .ext_val(ext_bv), .ext_en(ext_be),
    .level(lvl_b));
  pin_world world_c (.out(pc_o), .oe_n(pc_oen), .pull(pc_pu), .ext_val(ext_cv), .ext_en(ext_ce),
    .level(lvl_c));

  // free-running system clock
  initial
  begin
    forever #12.5 clock = ~clock;
  end

  // compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // wait n edges, then let their updates land
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // one configuration write, mirrored in the model
  task automatic set_cfg(input logic bank, input logic [31:0] en, dis, sela, selb, pe, pd);
    @(posedge clock);
    cfg_write <= 1'b1;
    cfg_bank <= bank;
    cfg <= '{periph_en: en, periph_dis: dis, sel_a: sela, sel_b: selb, pu_en: pe, pu_dis: pd};
    @(posedge clock);
    cfg_write <= 1'b0;
    m_st[bank] = (m_st[bank] | en) & ~dis;
    m_pu[bank] = (m_pu[bank] & ~pd) | pe;
    #1;
    chk(bank ? st_c : st_b, m_st[bank]);
    chk(bank ? pc_pu : pb_pu, m_pu[bank]);
  endtask

  // random traffic on the bus, interrupt, clock, bank c and bank b gpio inputs (bank b functions a and b stay fixed), then check the registered results
  task automatic rnd_step();
    logic [6:0] s;
    logic [31:0] q;
    logic [2:0] a;
    logic [7:0] c;
    logic [25:0] ad;
    logic d;
    logic n;
    logic [19:0] m;
    logic [31:0] e;
    logic [31:0] v;
    s = $random(seed);
    q = $random(seed);
    a = $random(seed);
    c = $random(seed);
    ad = $random(seed);
    d = $random(seed);
    n = $random(seed);
    m = $random(seed);
    @(posedge clock);
    sys_irq <= s;
    clk_req <= q;
    csa <= a;
    smc_cs <= c;
    sd_cs <= d;
    addr <= ad;
    n16 <= n;
    {bg, cg, cfa, cfb} <= {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
      $random(seed), $random(seed), $random(seed)};
    {dhi_o, dhi_oe, d32, rd_n, wr_n} <= m;
    tick(1);
    chk({31'h0, irq[1]}, {31'h0, |s});
    chk(clk_en, (q | 32'h2) & 32'h1fff_fffe);
    chk({24'h0, ebi_cs}, {24'h0, c[7:2], a[0] ? d : c[1], c[0]});
    chk({7'h0, ebi_addr}, {7'h0, ad[24:0]});
    chk({31'h0, nhi}, {31'h0, a[1] & n});
    // bank c function a lines: upper lanes, card enables, cs4 cs5, a25, nand strobes
    e = {{16{m[3] & m[2]}}, 8'h0, {2{a[2]}}, 3'h7, 1'b0, {2{a[1]}}};
    v = {m[19:4], 8'h0, {2{c[4] & c[5]}}, c[5], c[4], (a[2] ? m[0] : ad[25]), 1'b0, c[3] | m[0], c[3] | m[1]};
    chk(~pc_oen & 32'hffff_00fb, e);
    chk(pc_o & e, v & e);
    // the upper lanes come back through the synchroniser to the data bus input
    tick(2);
    chk({16'h0, dhi_i}, {16'h0, ((m[3] & m[2]) ? m[19:4] : m_pu[1][31:16])});
  endtask

  // report and end the run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // cut a hang short
  initial
  begin
    #(25 * 5000);
    failures++;
    close_out();
  end

  // main sequence
  initial
  begin
    m_st[0] = 32'h0;
    m_st[1] = 32'h8;
    m_pu[0] = 32'hffff_ffff;
    m_pu[1] = 32'hffff_ffff;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    tick(1);
    chk(st_b, 32'h0);
    chk(st_c, 32'h8);
    chk(pb_pu & pc_pu, 32'hffff_ffff);
    chk(pb_oen, 32'hffff_ffff);
    chk(pc_oen, 32'hffff_fff7);
    chk(clk_en, 32'h2);
    tick(3);
    chk({31'h0, boot}, 32'h0);
    // external interrupt levels on lines still owned by gpio must not reach the controller
    @(posedge clock);
    ext_be <= 32'h6000_0000;
    ext_ce <= 32'h0000_0804;
    tick(4);
    chk(irq & 32'he000_0001, 32'h0);
    set_cfg(1'b0, 32'h6000_0020, 32'h0, 32'h0, 32'h6000_0020, 32'h0, 32'h0);
    set_cfg(1'b1, 32'h0000_0804, 32'h0, 32'h0, 32'h0000_0804, 32'h0, 32'h0);
    tick(4);
    chk(irq & 32'he000_0003, 32'he000_0001);
    @(posedge clock);
    ext_be <= 32'h0;
    ext_ce <= 32'h0;
    tick(4);
    chk(irq & 32'he000_0001, 32'h0);
    // function b owns line b5: it drives the line, then reads back the board's low level, as gpio does; function a sees idle
    @(posedge clock);
    bfb <= '{val: 32'h20, en: 32'h20};
    bfa <= '{val: 32'h0, en: 32'hffff_ffff};
    tick(2);
    chk(pb_o & 32'h20, 32'h20);
    chk(pb_oen & 32'h20, 32'h0);
    @(posedge clock);
    bfb <= '{val: 32'h0, en: 32'h0};
    ext_be <= 32'h20;
    tick(4);
    chk(b_fbi & 32'h20, 32'h0);
    chk(b_fai & 32'h20, 32'h20);
    chk(b_gi & 32'h20, 32'h0);
    // both ownership strobes on one line: it goes back to gpio
    set_cfg(1'b0, 32'h20, 32'h20, 32'h0, 32'h0, 32'h0, 32'h0);
    for (int i = 0; i < 6; i++)
      set_cfg(i[0], $random(seed), $random(seed), $random(seed), $random(seed), $random(seed), $random(seed));
    // hand the memory lines of bank c back to function a, clearing any function b choice
    set_cfg(1'b1, 32'hffff_00fb, 32'h0, 32'hffff_00fb, 32'h0, 32'h0, 32'h0);
    for (int i = 0; i < 12; i++)
      rnd_step();
    close_out();
  end
endmodule // tb_top

// [design/io_glue_defines.svh]
// io_glue_defines.svh: sizes, line positions, reset values and ids for the io line mux glue
// assumes: included by bare name, after the package, in every design file that needs it
`ifndef IO_GLUE_DEFINES_SVH
`define IO_GLUE_DEFINES_SVH

// bank and source sizes
`define BANK_W 32
`define SYS_SRC_N 7
`define CSA_W 3

// interrupt controller identifiers
`define SYS_IRQ_ID 1
`define FIQ_ID 0
`define EXT_IRQ_LINE_0_ID 29
`define IRQ1_ID 30
`define EXT_IRQ_LINE_2_ID 31

// bits of the chip select assignment setting
`define CSA_CS1_SDRAM 0
`define CSA_CS3_NAND 1
`define CSA_CS45_CARD 2

// bank b line positions
`define B_PANEL_DEN 3
`define B_PANEL_LAST 20
`define B_EXT_IRQ_LINE_2 29
`define B_IRQ1 30

// bank c line positions
`define C_NAND_OE 0
`define C_NAND_WE 1
`define C_EXT_IRQ_LINE_0 2
`define C_A25 3
`define C_CS4 4
`define C_CS5 5
`define C_CE1 6
`define C_CE2 7
`define C_FIQ 11
`define C_DHI_LO 16

// reset values
`define PSR_B_RST 32'h0000_0000
`define PSR_C_RST 32'h0000_0008
`define ABSEL_RST 32'h0000_0000
`define PULLUP_RST 32'hffff_ffff
`define IDLE_IN 1'b1
`define BOOT_WAIT 2'h2

`endif

// [design/io_glue_pkg.sv]
// io_glue_pkg: types shared by the line mux cell and the glue top
// assumes: nothing beyond a synthesis tool that takes packed structs
package io_glue_pkg;

  // one bank's worth of drive: value and active-high enable
  typedef struct packed {
    logic [31:0] val;
    logic [31:0] en;
  } line_drive_s;

  // software configuration strobes for one bank; set and clear per line
  typedef struct packed {
    logic [31:0] periph_en;
    logic [31:0] periph_dis;
    logic [31:0] sel_a;
    logic [31:0] sel_b;
    logic [31:0] pu_en;
    logic [31:0] pu_dis;
  } line_cfg_s;

endpackage

// [design/io_glue_top.sv]
// io_glue_top: io line mux for banks b and c, system interrupt merge, clock enable mask, chip selects
// assumes: one 40 MHz clock, pins asynchronous, peripherals and memory controllers on this clock
`include "io_glue_defines.svh"

module io_glue_top (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // line configuration
  input wire logic cfg_write,
  input wire logic cfg_bank,
  input wire io_glue_pkg::line_cfg_s cfg,
  output logic [31:0] line_peripheral_status_b,
  output logic [31:0] line_peripheral_status_c,
  // bank b peripheral side
  input wire io_glue_pkg::line_drive_s bankb_gpio,
  input wire io_glue_pkg::line_drive_s bankb_fa,
  input wire io_glue_pkg::line_drive_s bankb_fb,
  output logic [31:0] bankb_gpio_in,
  output logic [31:0] bankb_fa_in,
  output logic [31:0] bankb_fb_in,
  // bank c peripheral side
  input wire io_glue_pkg::line_drive_s bankc_gpio,
  input wire io_glue_pkg::line_drive_s bankc_fa,
  input wire io_glue_pkg::line_drive_s bankc_fb,
  output logic [31:0] bankc_gpio_in,
  output logic [31:0] bankc_fa_in,
  output logic [31:0] bankc_fb_in,
  // pins
  input wire logic [31:0] pinb_in,
  output logic [31:0] pinb_out,
  output logic [31:0] pinb_oe_n,
  output logic [31:0] pinb_pullup,
  input wire logic [31:0] pinc_in,
  output logic [31:0] pinc_out,
  output logic [31:0] pinc_oe_n,
  output logic [31:0] pinc_pullup,
  output logic boot_mode_select_pin,
  // interrupts and clock enables
  input wire logic [6:0] sys_irq_src,
  output logic [31:0] irq_sources,
  input wire logic [31:0] clk_en_req,
  output logic [31:0] periph_clk_en,
  // external bus
  input wire logic [2:0] chip_select_assign_setting,
  input wire logic data_bus_32,
  input wire logic nand_16bit,
  input wire logic [7:0] smc_cs_n,
  input wire logic sdram_cs_n,
  input wire logic smc_rd_n,
  input wire logic smc_wr_n,
  input wire logic [25:0] addr,
  input wire logic [15:0] dhi_out,
  input wire logic dhi_oe,
  output logic [15:0] dhi_in,
  output logic [24:0] ebi_addr,
  output logic [7:0] ebi_cs_n,
  output logic nand_hi_lane_en
);

  logic [31:0] psr_b_reg, psr_b_next, psr_c_reg, psr_c_next;
  logic [31:0] absel_b_reg, absel_b_next, absel_c_reg, absel_c_next;
  logic [31:0] pu_b_reg, pu_b_next, pu_c_reg, pu_c_next;
  logic [31:0] syb1_reg, syb2_reg, syc1_reg, syc2_reg;
  logic [1:0] boot_cnt_reg, boot_cnt_next;
  logic boot_reg, boot_next;
  io_glue_pkg::line_drive_s pinb_mux, pinc_mux, bankc_fa_eff;
  logic [31:0] outb_reg, outb_next, oenb_reg, oenb_next;
  logic [31:0] outc_reg, outc_next, oenc_reg, oenc_next;
  logic [31:0] irq_reg, irq_next, clk_reg, clk_next;
  logic [7:0] cs_reg, cs_next;
  logic [24:0] addr_reg, addr_next;
  logic lane_reg, lane_next;
  logic nand_on, card_on;

  // line configuration: pu_en and sel_b win over their clears when both strobe, periph_dis wins over periph_en
  always_comb
  begin
    psr_b_next = psr_b_reg;
    absel_b_next = absel_b_reg;
    pu_b_next = pu_b_reg;
    psr_c_next = psr_c_reg;
    absel_c_next = absel_c_reg;
    pu_c_next = pu_c_reg;
    if (cfg_write && !cfg_bank)
    begin
      psr_b_next = (psr_b_reg & ~cfg.periph_en) | cfg.periph_dis;
      absel_b_next = (absel_b_reg & ~cfg.sel_a) | cfg.sel_b;
      pu_b_next = (pu_b_reg & ~cfg.pu_dis) | cfg.pu_en;
    end
    if (cfg_write && cfg_bank)
    begin
      psr_c_next = (psr_c_reg & ~cfg.periph_en) | cfg.periph_dis;
      absel_c_next = (absel_c_reg & ~cfg.sel_a) | cfg.sel_b;
      pu_c_next = (pu_c_reg & ~cfg.pu_dis) | cfg.pu_en;
    end
  end

  // status 1 means gpio owns the line; exported as peripheral status below
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      psr_b_reg <= ~`PSR_B_RST;
      psr_c_reg <= ~`PSR_C_RST;
      absel_b_reg <= `ABSEL_RST;
      absel_c_reg <= `ABSEL_RST;
      pu_b_reg <= `PULLUP_RST;
      pu_c_reg <= `PULLUP_RST;
    end
    else
    begin
      psr_b_reg <= psr_b_next;
      psr_c_reg <= psr_c_next;
      absel_b_reg <= absel_b_next;
      absel_c_reg <= absel_c_next;
      pu_b_reg <= pu_b_next;
      pu_c_reg <= pu_c_next;
    end
  end

  assign line_peripheral_status_b = ~psr_b_reg;
  assign line_peripheral_status_c = ~psr_c_reg;
  assign pinb_pullup = pu_b_reg;
  assign pinc_pullup = pu_c_reg;

  // two-stage synchronisers; idle level is high like the pullups
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      syb1_reg <= 32'hffff_ffff;
      syb2_reg <= 32'hffff_ffff;
      syc1_reg <= 32'hffff_ffff;
      syc2_reg <= 32'hffff_ffff;
    end
    else
    begin
      syb1_reg <= pinb_in;
      syb2_reg <= syb1_reg;
      syc1_reg <= pinc_in;
      syc2_reg <= syc1_reg;
    end
  end

  assign bankb_gpio_in = syb2_reg;
  assign bankc_gpio_in = syc2_reg;

  // boot level caught at the third edge after release, once the second stage holds the pin, not its reset value
  always_comb
  begin
    boot_cnt_next = boot_cnt_reg;
    boot_next = boot_reg;
    if (boot_cnt_reg <= `BOOT_WAIT)
    begin
      boot_cnt_next = boot_cnt_reg + 2'h1;
    end
    if (boot_cnt_reg == `BOOT_WAIT)
    begin
      boot_next = syb2_reg[`B_PANEL_DEN];
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      boot_cnt_reg <= 2'h0;
      boot_reg <= 1'b0;
    end
    else
    begin
      boot_cnt_reg <= boot_cnt_next;
      boot_reg <= boot_next;
    end
  end

  assign boot_mode_select_pin = boot_reg;

  // external bus: fixed function a lines of bank c, card and nand glue
  assign nand_on = chip_select_assign_setting[`CSA_CS3_NAND];
  assign card_on = chip_select_assign_setting[`CSA_CS45_CARD];
  always_comb
  begin
    bankc_fa_eff = bankc_fa;
    // nand strobes only while cs3 is active, any device width
    bankc_fa_eff.val[`C_NAND_OE] = ~(!smc_cs_n[3] && !smc_rd_n);
    bankc_fa_eff.en[`C_NAND_OE] = nand_on;
    bankc_fa_eff.val[`C_NAND_WE] = ~(!smc_cs_n[3] && !smc_wr_n);
    bankc_fa_eff.en[`C_NAND_WE] = nand_on;
    // top address bit or card read-not-write
    bankc_fa_eff.val[`C_A25] = card_on ? smc_wr_n : addr[25];
    bankc_fa_eff.en[`C_A25] = 1'b1;
    bankc_fa_eff.val[`C_CS4] = cs_next[4];
    bankc_fa_eff.en[`C_CS4] = 1'b1;
    bankc_fa_eff.val[`C_CS5] = cs_next[5];
    bankc_fa_eff.en[`C_CS5] = 1'b1;
    // card enables; width16 flag and ide select have no input here
    bankc_fa_eff.val[`C_CE1] = smc_cs_n[4] & smc_cs_n[5];
    bankc_fa_eff.en[`C_CE1] = card_on;
    bankc_fa_eff.val[`C_CE2] = smc_cs_n[4] & smc_cs_n[5];
    bankc_fa_eff.en[`C_CE2] = card_on;
    // upper data lanes only in 32-bit mode
    bankc_fa_eff.val[31:`C_DHI_LO] = dhi_out;
    bankc_fa_eff.en[31:`C_DHI_LO] = {16{dhi_oe && data_bus_32}};
  end

  assign dhi_in = bankc_fa_in[31:`C_DHI_LO];

  // line steering for both banks; bank b function a carries panel lines 0..20
  line_mux_bank u_bank_b (
    .periph(~psr_b_reg),
    .sel_b(absel_b_reg),
    .gpio(bankb_gpio),
    .fa(bankb_fa),
    .fb(bankb_fb),
    .pin_in(syb2_reg),
    .pin(pinb_mux),
    .fa_in(bankb_fa_in),
    .fb_in(bankb_fb_in)
  );

  line_mux_bank u_bank_c (
    .periph(~psr_c_reg),
    .sel_b(absel_c_reg),
    .gpio(bankc_gpio),
    .fa(bankc_fa_eff),
    .fb(bankc_fb),
    .pin_in(syc2_reg),
    .pin(pinc_mux),
    .fa_in(bankc_fa_in),
    .fb_in(bankc_fb_in)
  );

  // chip selects, interrupt sources and clock mask
  always_comb
  begin
    cs_next = smc_cs_n;
    if (chip_select_assign_setting[`CSA_CS1_SDRAM])
    begin
      cs_next[1] = sdram_cs_n;
    end
    addr_next = addr[24:0];
    lane_next = nand_on && nand_16bit;
    irq_next = 32'h0000_0000;
    irq_next[`SYS_IRQ_ID] = |sys_irq_src;
    irq_next[`FIQ_ID] = ~bankc_fb_in[`C_FIQ];
    irq_next[`EXT_IRQ_LINE_0_ID] = ~bankc_fb_in[`C_EXT_IRQ_LINE_0];
    irq_next[`IRQ1_ID] = ~bankb_fb_in[`B_IRQ1];
    irq_next[`EXT_IRQ_LINE_2_ID] = ~bankb_fb_in[`B_EXT_IRQ_LINE_2];
    clk_next = clk_en_req;
    clk_next[`SYS_IRQ_ID] = 1'b1;
    clk_next[`FIQ_ID] = 1'b0;
    clk_next[`EXT_IRQ_LINE_0_ID] = 1'b0;
    clk_next[`IRQ1_ID] = 1'b0;
    clk_next[`EXT_IRQ_LINE_2_ID] = 1'b0;
    outb_next = pinb_mux.val;
    oenb_next = ~pinb_mux.en;
    outc_next = pinc_mux.val;
    oenc_next = ~pinc_mux.en;
  end

  // output registers; peripheral-owned reset lines drive at once
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cs_reg <= 8'hff;
      addr_reg <= 25'h0000000;
      lane_reg <= 1'b0;
      irq_reg <= 32'h0000_0000;
      clk_reg <= 32'h0000_0002;
      outb_reg <= 32'h0000_0000;
      oenb_reg <= ~`PSR_B_RST;
      outc_reg <= 32'h0000_0000;
      oenc_reg <= ~`PSR_C_RST;
    end
    else
    begin
      cs_reg <= cs_next;
      addr_reg <= addr_next;
      lane_reg <= lane_next;
      irq_reg <= irq_next;
      clk_reg <= clk_next;
      outb_reg <= outb_next;
      oenb_reg <= oenb_next;
      outc_reg <= outc_next;
      oenc_reg <= oenc_next;
    end
  end

  assign ebi_cs_n = cs_reg;
  assign ebi_addr = addr_reg;
  assign nand_hi_lane_en = lane_reg;
  assign irq_sources = irq_reg;
  assign periph_clk_en = clk_reg;
  assign pinb_out = outb_reg;
  assign pinb_oe_n = oenb_reg;
  assign pinc_out = outc_reg;
  assign pinc_oe_n = oenc_reg;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_released;
    $rose(nrst);
  endsequence

  sequence s_sync_filled;
    s_released ##2 1'b1;
  endsequence

  a_reset_status: assert property (s_released |-> line_peripheral_status_c == `PSR_C_RST
    && line_peripheral_status_b == `PSR_B_RST && pinc_oe_n[`C_A25] == 1'b0)
    else $error("line status wrong after reset");
  a_boot_latch: assert property (s_sync_filled |=> boot_mode_select_pin == $past(syb2_reg[`B_PANEL_DEN]))
    else $error("boot mode level not caught");
  a_sys_irq_or: assert property ((|sys_irq_src) |=> irq_sources[`SYS_IRQ_ID])
    else $error("system interrupt missing");
  a_sys_irq_quiet: assert property ((sys_irq_src == 7'h00) |=> !irq_sources[`SYS_IRQ_ID])
    else $error("system interrupt without source");
  a_sys_clk_on: assert property (##1 periph_clk_en[`SYS_IRQ_ID])
    else $error("system clock enable dropped");
  a_ext_clk_off: assert property (##1 !periph_clk_en[`EXT_IRQ_LINE_0_ID] && !periph_clk_en[`FIQ_ID])
    else $error("external irq id got a clock");
  a_cs1_route: assert property (chip_select_assign_setting[`CSA_CS1_SDRAM] |=> ebi_cs_n[1] == $past(sdram_cs_n))
    else $error("cs1 not routed to dynamic controller");
  a_cs0_static: assert property (##1 ebi_cs_n[0] == $past(smc_cs_n[0]) && ebi_cs_n[2] == $past(smc_cs_n[2]))
    else $error("cs0 or cs2 not static");
  a_nand_lane: assert property (nand_on && nand_16bit |=> nand_hi_lane_en)
    else $error("nand upper lane not enabled");
  a_unsel_inactive: assert property ((bankb_fb_in | (~psr_b_reg & absel_b_reg)) == 32'hffff_ffff)
    else $error("unselected function sees the line");

endmodule // io_glue_top

// [design/line_mux_bank.sv]
// line_mux_bank: combinational steering of one bank of io lines to gpio, function a or function b
// assumes: pin input already synchronised; pin drive registered by the instantiating module, fa_in and fb_in passed out unregistered
`include "io_glue_defines.svh"

module line_mux_bank (
  // selection state
  input wire logic [31:0] periph,
  input wire logic [31:0] sel_b,
  // sources
  input wire io_glue_pkg::line_drive_s gpio,
  input wire io_glue_pkg::line_drive_s fa,
  input wire io_glue_pkg::line_drive_s fb,
  // synchronised pin level
  input wire logic [31:0] pin_in,
  // results
  output io_glue_pkg::line_drive_s pin,
  output logic [31:0] fa_in,
  output logic [31:0] fb_in
);

  // per line: drive from the owner, inputs only reach the owner
  always_comb
  begin
    for (int i = 0; i < `BANK_W; i++)
    begin
      if (!periph[i])
      begin
        pin.val[i] = gpio.val[i];
        pin.en[i] = gpio.en[i];
      end
      else if (sel_b[i])
      begin
        pin.val[i] = fb.val[i];
        pin.en[i] = fb.en[i];
      end
      else
      begin
        pin.val[i] = fa.val[i];
        pin.en[i] = fa.en[i];
      end
      fa_in[i] = (periph[i] && !sel_b[i]) ? pin_in[i] : `IDLE_IN;
      fb_in[i] = (periph[i] && sel_b[i]) ? pin_in[i] : `IDLE_IN;
    end
  end

endmodule // line_mux_bank
